// ==== core/ecd_datapath.sv ====
// instruction execution datapath of the eight-op control processor
`timescale 1ns/10ps
module ecd_datapath import ecd_pkg::*; #(
    parameter int PC_W = ECD_PC_W      // program address width, 9..13
) (
    input wire logic ref_clk,                // 20 MHz clock
    input wire logic rstn,                   // async reset, active low
    output logic [PC_W-1:0] prog_addr,       // program memory address
    input wire logic [15:0] prog_data,       // instruction at prog_addr
    output logic [7:0] io_addr,              // selected interface byte
    input wire logic [7:0] io_rdata,         // interface byte read value
    output logic [7:0] io_wdata,             // interface byte written value
    output logic io_we                       // interface write strobe, one cycle
);
    logic [1:0] rst_sync_r;                  // reset release synchroniser
    logic rst_n;                             // synchronised reset
    ecd_phase_t phase_r;                     // fetch or execute
    ecd_mode_t mode_r;                       // sequential or indexed entry
    ecd_instr_t instr_r;                     // latched instruction
    logic [PC_W-1:0] pc_r, pc_nxt;           // program counter
    logic [PC_W-1:0] ret_r;                  // return point after indexed execute
    logic [7:0] gpr_r [ECD_NUM_GPR];         // aux and general registers
    logic ovf_r;                             // carry register
    logic [7:0] ws_sel_r;                    // storage_select_reg
    logic [7:0] io_sel_r;                    // io_select_reg
    logic [7:0] io_wdata_r;                  // interface output byte
    logic io_we_r;                           // interface write pulse
    logic [7:0] ws_rdata;                    // selected storage byte
    logic [7:0] alu_res;                     // operation result

    // release reset through two flops; only the second is used
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // decode of the latched instruction
    wire logic [15:0] ibits = instr_r;                     // raw word
    wire ecd_op_t op = instr_r.op;                         // opcode
    wire logic exec = (phase_r == ST_EXEC);                // execute cycle
    wire logic is_alu = (op == OP_MOVE) || (op == OP_ADD) ||
                        (op == OP_AND) || (op == OP_XOR); // two-operand ops
    wire logic is_literal_load = (op == OP_LITERAL_LOAD);                  // literal_load
    wire logic [7:0] literal = ibits[7:0];                 // immediate byte
    wire logic [4:0] src_code = instr_r.a;                 // source operand
    wire logic [4:0] dst_code = is_literal_load ? instr_r.a : instr_r.c; // destination
    wire logic [2:0] len_raw = is_alu ? instr_r.b : 3'h0;  // rotate or length
    wire logic [3:0] len8 = (len_raw == 3'h0) ? ECD_BYTE_BITS : {1'b0, len_raw};

    // source value: rotated register or extracted field
    wire logic src_is_field = src_code[4];                 // field operand
    wire logic [7:0] src_byte = src_code[3] ? io_rdata : ws_rdata; // bank pick
    wire logic [7:0] fmask = ECD_ONES >> (ECD_BYTE_BITS - len8); // field mask
    wire logic [7:0] src_field = (src_byte >> src_code[2:0]) & fmask;
    wire logic [7:0] reg_val = (src_code[2:0] == ECD_OVF_IDX) ? {7'h00, ovf_r}
                               : gpr_r[src_code[2:0]];     // carry readable
    wire logic [15:0] rot2 = {reg_val, reg_val} >> len_raw; // wrap lsb to msb
    // the rotate acts on a copy; the register itself is not written
    wire logic [7:0] src_val = src_is_field ? src_field
                               : (src_code[3] ? ECD_ZERO : rot2[7:0]);
    wire logic [8:0] sum9 = {1'b0, src_val} + {1'b0, gpr_r[ECD_AUX_IDX]};

    // operation result
    always_comb begin
        unique case (op)
            OP_MOVE: alu_res = src_val;                          // copy
            OP_ADD: alu_res = sum9[7:0];
            OP_AND: alu_res = src_val & gpr_r[ECD_AUX_IDX];
            OP_XOR: alu_res = src_val ^ gpr_r[ECD_AUX_IDX];
            OP_LITERAL_LOAD: alu_res = literal;                          // two's compl
            default: alu_res = ECD_ZERO;                         // branches write nothing
        endcase
    end

    // destination merge: only bits of the field change
    wire logic dst_is_field = dst_code[4];                 // field destination
    wire logic dst_io = dst_code[3];                       // interface bank
    wire logic [7:0] dst_byte = dst_io ? io_rdata : ws_rdata; // byte being merged
    wire logic [7:0] dmask = fmask << dst_code[2:0];       // bits replaced
    // source and destination may sit in one byte or in both banks
    wire logic [7:0] merged = (dst_byte & ~dmask) | ((alu_res & fmask) << dst_code[2:0]);
    wire logic writes = exec && (is_alu || is_literal_load);       // result is stored
    wire logic ws_we = writes && dst_is_field && !dst_io;  // storage write
    wire logic io_we_nxt = writes && dst_is_field && dst_io; // interface write
    wire logic reg_dst = writes && (dst_code[4:3] == 2'h0); // register write

    // branch targets; tables and nonzero branches stay in the current 256-word page, jumps are absolute
    wire logic [PC_W-1:0] pc_inc = pc_r + 1'b1;            // next sequential
    wire logic [PC_W-1:0] seq_next = (mode_r == MD_INDEXED) ? ret_r : pc_inc;
    wire logic [PC_W-1:0] jmp_tgt = ibits[PC_W-1:0];       // absolute jump
    wire logic [PC_W-1:0] nzt_tgt = {pc_r[PC_W-1:8], literal}; // branch target
    wire logic [7:0] xec_low = literal + src_val;          // index 0 = first entry
    wire logic [PC_W-1:0] xec_tgt = {pc_r[PC_W-1:8], xec_low}; // table entry
    wire logic nz = (src_val != ECD_ZERO);                 // nonzero

    // next program counter
    always_comb begin
        unique case (op)
            OP_JMP: pc_nxt = jmp_tgt;                      // also from a table
            OP_NZT: pc_nxt = nz ? nzt_tgt : seq_next;
            OP_XEC: pc_nxt = xec_tgt;
            default: pc_nxt = seq_next;                    // return after entry
        endcase
    end

    // sequencing: each instruction takes a fetch and an execute cycle,
    // which gives the storage memory its read cycle after a select change
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= ST_FETCH;
            instr_r <= '0;
        end else if (!exec) begin
            phase_r <= ST_EXEC;
            instr_r <= ecd_instr_t'(prog_data);
        end else begin
            phase_r <= ST_FETCH;
        end
    end

    // program counter, indexed mode and return point
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= '0;
            ret_r <= '0;
            mode_r <= MD_SEQ;
        end else if (exec) begin
            pc_r <= pc_nxt;
            mode_r <= (op == OP_XEC) ? MD_INDEXED : MD_SEQ;  // one entry only
            if (op == OP_XEC && mode_r == MD_SEQ) begin
                ret_r <= pc_inc;                             // resume after it
            end
        end
    end

    // aux and general registers, one writer per register
    for (genvar g = 0; g < ECD_NUM_GPR; g++) begin : g_gpr
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                gpr_r[g] <= ECD_ZERO;
            end else if (reg_dst && dst_code[2:0] == 3'(g)) begin
                gpr_r[g] <= alu_res;
            end
        end
    end

    // carry, select registers and interface output
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_r <= 1'b0;
            ws_sel_r <= ECD_ZERO;
            io_sel_r <= ECD_ZERO;
            io_wdata_r <= ECD_ZERO;
            io_we_r <= 1'b0;
        end else begin
            io_we_r <= io_we_nxt;
            if (io_we_nxt) begin
                io_wdata_r <= merged;
            end
            if (exec && op == OP_ADD) begin
                ovf_r <= sum9[8];
            end
            if (writes && dst_code == ECD_SEL_WS) begin
                ws_sel_r <= alu_res;
            end
            if (writes && dst_code == ECD_SEL_IO) begin
                io_sel_r <= alu_res;
            end
        end
    end

    // working storage; always reads the selected byte
    ecd_ws_mem #(.DEPTH(ECD_WS_DEPTH), .AW(8)) u_ws (
        .clk(ref_clk),
        .we(ws_we),
        .addr(ws_sel_r),
        .wdata(merged),
        .rdata(ws_rdata)
    );

    assign prog_addr = pc_r;
    assign io_addr = io_sel_r;
    assign io_wdata = io_wdata_r;
    assign io_we = io_we_r;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    copy_to_aux_a: assert property (exec && op == OP_MOVE && dst_code == 5'h00
        |=> gpr_r[ECD_AUX_IDX] == $past(src_val)) else $error("copy to aux wrong");
    rotate_keep_a: assert property (exec && src_code == 5'h01 && dst_code != 5'h01
        |=> $stable(gpr_r[1])) else $error("rotated source changed");
    add_carry_a: assert property (exec && op == OP_ADD
        |=> ovf_r == $past(sum9[8])) else $error("carry not captured");
    and_mask_a: assert property (exec && op == OP_AND && gpr_r[ECD_AUX_IDX] == 8'h0f
        |-> alu_res[7:4] == 4'h0) else $error("and mask failed");
    xor_comp_a: assert property (exec && op == OP_XOR && gpr_r[ECD_AUX_IDX] == ECD_ONES
        |-> alu_res == ~src_val) else $error("xor complement failed");
    io_write_a: assert property (io_we_nxt
        |=> io_we && io_wdata == $past(merged) ##1 !io_we) else $error("io write wrong");
    field_keep_a: assert property (ws_we
        |-> ((merged ^ ws_rdata) & ~dmask) == ECD_ZERO) else $error("field spill");
    sel_load_a: assert property (exec && is_literal_load && dst_code == ECD_SEL_WS
        |=> ws_sel_r == $past(literal)) else $error("storage select not loaded");
    xec_return_a: assert property (exec && mode_r == MD_INDEXED && (is_alu || is_literal_load)
        |=> pc_r == $past(ret_r) && mode_r == MD_SEQ) else $error("no return");
    jump_load_a: assert property (exec && op == OP_JMP
        |=> pc_r == $past(jmp_tgt)) else $error("jump target wrong");
    nzt_fall_a: assert property (exec && op == OP_NZT && !nz && mode_r == MD_SEQ
        |=> pc_r == $past(pc_inc)) else $error("branch fell wrong");

    xec_run_c: cover property (exec && op == OP_XEC ##2 exec && op == OP_JMP);
    nzt_taken_c: cover property (exec && op == OP_NZT && nz);
    add_carry_c: cover property (exec && op == OP_ADD && sum9[8]);
    io_field_c: cover property (io_we_nxt && len8 != ECD_BYTE_BITS);
endmodule : ecd_datapath

// ==== core/ecd_pkg.sv ====
// shared constants and types for the eight-op control datapath
package ecd_pkg;
    // widths and sizes
    localparam int ECD_PC_W = 13;             // program counter width
    localparam int ECD_WS_DEPTH = 256;        // working storage bytes
    localparam int ECD_NUM_GPR = 7;           // aux plus six general registers
    // operand code map (5-bit source / destination codes)
    localparam logic [2:0] ECD_AUX_IDX = 3'h0;   // implicit operand register
    localparam logic [2:0] ECD_OVF_IDX = 3'h7;   // carry register, read only
    localparam logic [4:0] ECD_SEL_WS = 5'h08;   // storage_select_reg
    localparam logic [4:0] ECD_SEL_IO = 5'h09;   // io_select_reg
    // arithmetic constants
    localparam logic [3:0] ECD_BYTE_BITS = 4'h8; // bits per byte, full field
    localparam logic [7:0] ECD_ONES = 8'hff;     // all-ones byte
    localparam logic [7:0] ECD_ZERO = 8'h00;     // all-zero byte

    // instruction opcodes
    typedef enum logic [2:0] {
        OP_MOVE = 3'h0,
        OP_ADD = 3'h1,
        OP_AND = 3'h2,
        OP_XOR = 3'h3,
        OP_LITERAL_LOAD = 3'h4,
        OP_XEC = 3'h5,
        OP_NZT = 3'h6,
        OP_JMP = 3'h7
    } ecd_op_t;

    // instruction word: a=source (or literal_load dest), b=length/rotate, c=dest
    typedef struct packed {
        ecd_op_t op;       // opcode
        logic [4:0] a;     // source code
        logic [2:0] b;     // rotate count or field length (0 = 8)
        logic [4:0] c;     // destination code
    } ecd_instr_t;

    // sequencing phase and execution mode
    typedef enum logic {ST_FETCH, ST_EXEC} ecd_phase_t;
    typedef enum logic {MD_SEQ, MD_INDEXED} ecd_mode_t;
endpackage : ecd_pkg

// ==== core/ecd_ws_mem.sv ====
// working storage byte memory with registered read data
`timescale 1ns/10ps
module ecd_ws_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk,              // system clock
    input wire logic we,               // write strobe
    input wire logic [AW-1:0] addr,    // byte address
    input wire logic [7:0] wdata,      // write byte
    output logic [7:0] rdata           // registered read byte
);
    logic [7:0] mem [DEPTH];           // storage array, no reset by design

    // write then registered read; read sees a write one cycle later
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : ecd_ws_mem

// ==== testbench/ecd_datapath_test.sv ====
// self-checking bench: small programs run on the datapath, results read from the bank
`timescale 1ns/10ps
module ecd_datapath_test import ecd_pkg::*;;
    logic ref_clk = 1'b0; // 20 MHz clock
    logic rstn = 1'b0; // active-low reset
    logic [12:0] prog_addr; // program counter
    logic [15:0] prog_data; // instruction word
    logic [7:0] io_addr; // selected interface byte
    logic [7:0] io_rdata; // bank read value
    logic [7:0] io_wdata; // bank write value
    logic io_we; // bank write strobe
    logic [15:0] rom [0:8191]; // program memory, answered combinationally
    int err_count = 0; // mismatches
    int num_checks = 0; // comparisons made
    // half period of 25 ns
    always #25 ref_clk = ~ref_clk;
    assign prog_data = rom[prog_addr];
    ecd_datapath DUT (.ref_clk(ref_clk), .rstn(rstn), .prog_addr(prog_addr),
        .prog_data(prog_data), .io_addr(io_addr), .io_rdata(io_rdata),
        .io_wdata(io_wdata), .io_we(io_we));
    ecd_io_bank io_side (.ref_clk(ref_clk), .io_addr(io_addr), .io_rdata(io_rdata),
        .io_wdata(io_wdata), .io_we(io_we));
    // register/field operation word
    function automatic logic [15:0] ix(ecd_op_t op, logic [4:0] a, logic [2:0] b,
            logic [4:0] c);
        return {op, a, b, c};
    endfunction : ix
    // word carrying an 8-bit literal
    function automatic logic [15:0] il(ecd_op_t op, logic [4:0] a, logic [7:0] v);
        return {op, a, v};
    endfunction : il
    // one compare for every byte result
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    // hold the core in reset and fill memory with self-jumps so stray runs stop
    task automatic hold_reset;
        @(negedge ref_clk);
        rstn = 1'b0;
        for (int i = 0; i < 8192; i++) begin
            rom[i] = {OP_JMP, i[12:0]};
        end
    endtask : hold_reset
    // reset for 3 cycles, check idle outputs, then let the program run n cycles
    task automatic go(input int n);
        repeat (3) @(negedge ref_clk);
        chk8(io_wdata, 8'h00);
        chk8({7'h00, io_we}, 8'h00);
        rstn = 1'b1;
        repeat (n) @(negedge ref_clk);
    endtask : go
    // literal load, copy to the bank, rotated copy, source left intact
    task automatic t_move_rotate;
        hold_reset();
        rom[0] = il(OP_LITERAL_LOAD, 5'h09, 8'h05);
        rom[1] = il(OP_LITERAL_LOAD, 5'h01, 8'hf5); // minus eleven
        rom[2] = ix(OP_MOVE, 5'h01, 3'h0, 5'h18);
        rom[3] = il(OP_LITERAL_LOAD, 5'h09, 8'h06);
        // rotate into a register: b is also the length of a field destination
        rom[4] = ix(OP_MOVE, 5'h01, 3'h3, 5'h02);
        rom[5] = ix(OP_MOVE, 5'h02, 3'h0, 5'h18);
        rom[6] = il(OP_LITERAL_LOAD, 5'h09, 8'h07);
        rom[7] = ix(OP_MOVE, 5'h01, 3'h0, 5'h18);
        go(30);
        chk8(io_side.bank[8'h05], 8'hf5);
        chk8(io_side.bank[8'h06], 8'hbe);
        chk8(io_side.bank[8'h07], 8'hf5);
        chk8(io_addr, 8'h07);
    endtask : t_move_rotate
    // and, xor and add against the implicit operand, then the carry
    task automatic t_alu;
        hold_reset();
        rom[0] = il(OP_LITERAL_LOAD, 5'h00, 8'h0f);
        rom[1] = il(OP_LITERAL_LOAD, 5'h03, 8'ha7);
        rom[2] = il(OP_LITERAL_LOAD, 5'h09, 8'h08);
        rom[3] = ix(OP_AND, 5'h03, 3'h0, 5'h18);
        rom[4] = il(OP_LITERAL_LOAD, 5'h00, 8'hff);
        rom[5] = il(OP_LITERAL_LOAD, 5'h09, 8'h09);
        rom[6] = ix(OP_XOR, 5'h03, 3'h0, 5'h18);
        rom[7] = il(OP_LITERAL_LOAD, 5'h04, 8'h80);
        rom[8] = ix(OP_MOVE, 5'h04, 3'h0, 5'h00); // copy into the implicit operand
        rom[9] = il(OP_LITERAL_LOAD, 5'h04, 8'h90);
        rom[10] = il(OP_LITERAL_LOAD, 5'h09, 8'h0a);
        rom[11] = ix(OP_ADD, 5'h04, 3'h0, 5'h18);
        rom[12] = il(OP_LITERAL_LOAD, 5'h09, 8'h0b);
        rom[13] = ix(OP_MOVE, 5'h07, 3'h0, 5'h18);
        go(40);
        chk8(io_side.bank[8'h08], 8'h07);
        chk8(io_side.bank[8'h09], 8'h58);
        chk8(io_side.bank[8'h0a], 8'h10);
        chk8(io_side.bank[8'h0b], 8'h01);
    endtask : t_alu
    // narrow field writes, storage select, storage to bank, same-byte fields
    task automatic t_fields;
        hold_reset();
        io_side.bank[8'h0c] = 8'haa;
        rom[0] = il(OP_LITERAL_LOAD, 5'h09, 8'h0c);
        rom[1] = il(OP_LITERAL_LOAD, 5'h01, 8'h0c); // rotated right two gives 3 in the field
        rom[2] = ix(OP_MOVE, 5'h01, 3'h2, 5'h1a);
        rom[3] = il(OP_LITERAL_LOAD, 5'h08, 8'h40);
        rom[4] = il(OP_LITERAL_LOAD, 5'h02, 8'h3c);
        rom[5] = ix(OP_MOVE, 5'h02, 3'h0, 5'h10);
        rom[6] = il(OP_LITERAL_LOAD, 5'h08, 8'h41);
        rom[7] = il(OP_LITERAL_LOAD, 5'h02, 8'h99);
        rom[8] = ix(OP_MOVE, 5'h02, 3'h0, 5'h10);
        rom[9] = il(OP_LITERAL_LOAD, 5'h08, 8'h40);
        rom[10] = il(OP_LITERAL_LOAD, 5'h09, 8'h0d);
        rom[11] = ix(OP_MOVE, 5'h10, 3'h0, 5'h18);
        rom[12] = ix(OP_MOVE, 5'h18, 3'h2, 5'h1c);
        go(40);
        chk8(io_side.bank[8'h0c], 8'hae);
        chk8(io_side.bank[8'h0d], 8'h0c);
    endtask : t_fields
    // indexed execute, redirect from a table entry, nonzero branch both ways
    task automatic t_branch;
        hold_reset();
        rom[0] = il(OP_LITERAL_LOAD, 5'h09, 8'h20);
        rom[1] = il(OP_LITERAL_LOAD, 5'h01, 8'h02);
        rom[2] = il(OP_XEC, 5'h01, 8'h40);
        rom[3] = ix(OP_MOVE, 5'h05, 3'h0, 5'h18);
        rom[4] = il(OP_LITERAL_LOAD, 5'h01, 8'h00);
        rom[5] = il(OP_XEC, 5'h01, 8'h50);
        rom[6] = il(OP_LITERAL_LOAD, 5'h05, 8'hee);
        rom[7] = il(OP_LITERAL_LOAD, 5'h05, 8'hee);
        rom[8] = il(OP_LITERAL_LOAD, 5'h09, 8'h21);
        rom[9] = ix(OP_MOVE, 5'h05, 3'h0, 5'h18);
        rom[10] = il(OP_NZT, 5'h01, 8'h0c);
        rom[11] = il(OP_LITERAL_LOAD, 5'h05, 8'h66);
        rom[12] = il(OP_LITERAL_LOAD, 5'h09, 8'h22);
        rom[13] = ix(OP_MOVE, 5'h05, 3'h0, 5'h18);
        rom[14] = il(OP_LITERAL_LOAD, 5'h01, 8'h01);
        rom[15] = il(OP_NZT, 5'h01, 8'h11);
        rom[16] = il(OP_LITERAL_LOAD, 5'h05, 8'h77);
        rom[17] = il(OP_LITERAL_LOAD, 5'h09, 8'h23);
        rom[18] = ix(OP_MOVE, 5'h05, 3'h0, 5'h18);
        rom[8'h40] = il(OP_LITERAL_LOAD, 5'h05, 8'h11);
        rom[8'h41] = il(OP_LITERAL_LOAD, 5'h05, 8'h22);
        rom[8'h42] = il(OP_LITERAL_LOAD, 5'h05, 8'h33);
        rom[8'h50] = {OP_JMP, 13'h0008};
        go(80);
        chk8(io_side.bank[8'h20], 8'h33);
        chk8(io_side.bank[8'h21], 8'h33);
        chk8(io_side.bank[8'h22], 8'h66);
        chk8(io_side.bank[8'h23], 8'h66);
        chk8(prog_addr[7:0], 8'h13);
    endtask : t_branch
    // verdict and end of run, reached from the main sequence or the watchdog
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    // main sequence
    initial begin
        t_move_rotate();
        t_alu();
        t_fields();
        t_branch();
        chk8(io_side.bad_we[7:0], 8'h00);
        test_done();
    end
    // watchdog: a hung run counts as a mismatch
    initial begin
        #2000000;
        err_count++;
        test_done();
    end
endmodule : ecd_datapath_test

// ==== testbench/ecd_io_bank.sv ====
// interface byte bank model: the system logic on the datapath's left bank
`timescale 1ns/10ps
module ecd_io_bank (
    input wire logic ref_clk, // system clock
    input wire logic [7:0] io_addr, // selected interface byte
    output logic [7:0] io_rdata, // read value of the selected byte
    input wire logic [7:0] io_wdata, // byte written by the datapath
    input wire logic io_we // write strobe from the datapath
);
    logic [7:0] bank [0:255]; // external interface bytes
    logic we_d = 1'b0; // strobe seen one cycle back
    int bad_we = 0; // strobes that stood longer than one cycle
    // seed every byte with a known pattern so no read returns unknowns
    initial begin
        for (int i = 0; i < 256; i++) begin
            bank[i] = i[7:0] ^ 8'h5a;
        end
    end
    // external logic answers at once, with no wait state
    assign io_rdata = bank[io_addr];
    // capture each write; system logic may use it from the next edge on
    always @(posedge ref_clk) begin
        if (io_we === 1'b1) begin
            bank[io_addr] <= io_wdata;
        end
        if (io_we === 1'b1 && we_d === 1'b1) begin
            bad_we <= bad_we + 1; // two writes never come closer than two cycles
        end
        we_d <= io_we;
    end
endmodule : ecd_io_bank
